// file: bench/ext_source.sv
// Model of the external count sources of the timer units
module ext_source (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Sources that run
    input  wire logic [3:0] run,
    // Count lines
    output logic      [3:0] ext_count_input
);
    logic [1:0] phase;
    // Period of eight clocks while running, frozen otherwise
    always_ff @(posedge mclk) begin
        if (reset || run == 4'h0) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
        if (reset) begin
            ext_count_input <= 4'h0;
        end else begin
            ext_count_input <= ext_count_input ^ (run & {4{phase == 2'h3}});
        end
    end
endmodule : ext_source

// file: bench/timer_frame_monitor.sv
// Port checker of the timer frame
module timer_frame_monitor (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and interrupt
    input wire logic [3:0]  ext_count_input,
    input wire logic [1:0]  periodic_port_data,
    input wire logic [4:0]  alt_pin_level,
    input wire logic        periodic_out_primary,
    input wire logic        periodic_out_secondary,
    input wire logic [3:1]  timer_out_pin,
    input wire logic        irq
);
    logic       rd_setup;
    logic       wr_done;
    logic [4:0] pins;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_done = psel && penable && pwrite;
    assign pins = {timer_out_pin, periodic_out_secondary,
                   periodic_out_primary};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    AST_READY: assert property (psel && penable |-> pready && !pslverr)
        else $error("APB access not answered at once");
    AST_RESET_PINS: assert property ($past(reset)
        |-> pins == alt_pin_level)
        else $error("Pins not on other function after reset");
    AST_RESET_IRQ: assert property ($past(reset) |-> !irq)
        else $error("Interrupt high after reset");
    AST_UNMAPPED: assert property (rd_setup && paddr == 32'h0000_008C
        |=> prdata == 32'h0000_0000) else $error("Unmapped read not zero");
    AST_COUNT_WIDTH: assert property (rd_setup && paddr[4:0] == 5'h0C
        && paddr < 32'h0000_0080 |=> prdata[31:10] == 22'h00_0000)
        else $error("Count wider than ten bits");
    AST_PIN_RELEASE: assert property (wr_done && paddr == 32'h0000_0080
        && pwdata[4:0] == 5'h00 |=> pins == alt_pin_level)
        else $error("Pins kept timer function");
    AST_MASK_OFF: assert property (wr_done && paddr == 32'h0000_0088
        && pwdata[7:0] == 8'h00 |=> !irq) else $error("Masked interrupt high");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_done)
        || $past(reset)) else $error("Interrupt fell without a write");
    AST_PRDATA_HOLD: assert property (!rd_setup |=> $stable(prdata))
        else $error("Read data changed without a read");
endmodule : timer_frame_monitor

bind timer_frame timer_frame_monitor mon (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_input(ext_count_input), .alt_pin_level(alt_pin_level),
    .periodic_port_data(periodic_port_data), .irq(irq),
    .periodic_out_primary(periodic_out_primary),
    .periodic_out_secondary(periodic_out_secondary),
    .timer_out_pin(timer_out_pin));

// file: bench/timer_frame_tb_top.sv
// Self-checking bench of the timer frame
module timer_frame_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_frame_pkg::*;
    logic        mclk = 1'b0;
    logic        reset, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        pready, pslverr, prim, sec, irq;
    logic [3:0]  ext_count_input, run;
    logic [1:0]  periodic_port_data;
    logic [4:0]  alt_pin_level;
    logic [3:1]  timer_out_pin;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #2 mclk = ~mclk;
    timer_frame dut (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_input(ext_count_input), .alt_pin_level(alt_pin_level),
        .periodic_port_data(periodic_port_data), .irq(irq),
        .periodic_out_primary(prim), .periodic_out_secondary(sec),
        .timer_out_pin(timer_out_pin));
    ext_source src (.mclk(mclk), .reset(reset), .run(run),
        .ext_count_input(ext_count_input));
    ////////////////////////////////////////
    task chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task apb_wr(input logic [31:0] a, d);
        psel <= 1'b1; pwrite <= 1'b1; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb_wr
    task apb_rd(input logic [31:0] a, output logic [31:0] d);
        psel <= 1'b1; pwrite <= 1'b0; paddr <= a;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        d = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb_rd
    task report_and_stop;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    task t_regs;
        for (int u = 0; u < 4; u++) begin
            apb_rd(32'(u) << 5, rd); chk("ctrl", rd, 32'h0);
        end
        apb_rd(32'h80, rd); chk("pinctl", rd, 32'h0);
        apb_wr(32'h8C, 32'hFFFF_FFFF);
        apb_rd(32'h8C, rd); chk("unmapped", rd, 32'h0);
        apb_wr(32'h24, 32'hFFFF_FFFF);
        apb_rd(32'h24, rd); chk("cmp", rd, 32'h3FF);
    endtask : t_regs
    task t_match;
        logic [31:0] b;
        for (int u = 0; u < 4; u++) begin
            b = 32'(u) << 5;
            apb_wr(b + 4, 32'h5); apb_wr(b + 8, 32'h9);
            apb_wr(32'h88, 32'hFF); apb_wr(b, 32'h105);
            repeat (30) @(posedge mclk);
            apb_rd(b + 12, rd); chk("clear", rd <= 32'h9, 32'h1);
            apb_rd(32'h84, rd); chk("sts", rd, 32'h3 << (2 * u));
            chk("irq", irq, 32'h1);
            apb_wr(32'h88, 32'h0); chk("masked", irq, 32'h0);
            apb_wr(b, 32'h0); apb_wr(32'h84, 32'hFF); apb_wr(32'h88, 32'hFF);
            apb_rd(32'h84, rd); chk("w1c", rd, 32'h0);
            chk("irq off", irq, 32'h0);
        end
    endtask : t_match
    task t_ext;
        logic [31:0] mode [3] = '{32'h15, 32'h1D, 32'h3D};
        apb_wr(32'h44, 32'h3E8); apb_wr(32'h48, 32'h3E8);
        for (int k = 0; k < 3; k++) begin
            apb_wr(32'h40, 32'h0); apb_wr(32'h40, mode[k]);
            run <= 4'hF; repeat (40) @(posedge mclk);
            run <= 4'h0; repeat (12) @(posedge mclk);
            apb_rd(32'h4C, rd); chk("ext", rd, 32'h5);
        end
        apb_wr(32'h40, 32'h0);
    endtask : t_ext
    // Unit three on each divided rate; 512 edges hold whole periods
    task t_div;
        logic [31:0] sel [5] = '{32'h0, 32'h2, 32'h3, 32'h4, 32'h6};
        logic [31:0] want [5] = '{32'h80, 32'h20, 32'h8, 32'h2, 32'h0};
        for (int k = 0; k < 5; k++) begin
            apb_wr(32'h60, 32'h0);
            apb_wr(32'h60, 32'h1 | (sel[k] << 2));
            repeat (511) @(posedge mclk);
            apb_rd(32'h6C, rd);
            chk("prescale", rd, want[k]);
        end
        apb_wr(32'h60, 32'h0);
    endtask : t_div
    task t_pins;
        logic [31:0] mode [4] = '{32'h405, 32'h445, 32'h085, 32'h0C5};
        logic [3:0]  lvl = 4'b1101;
        logic        e;
        for (int u = 0; u < 4; u++) begin
            apb_wr((32'(u) << 5) + 4, 32'h14);
            apb_wr((32'(u) << 5) + 8, 32'h14);
        end
        apb_wr(32'h80, 32'h1F);
        for (int k = 0; k < 4; k++) begin
            for (int u = 0; u < 4; u++) begin
                apb_wr(32'(u) << 5, 32'h0); apb_wr(32'(u) << 5, mode[k]);
            end
            repeat (60) @(posedge mclk);
            e = lvl[k];
            chk("pins", {timer_out_pin, sec, prim},
                {e, e, e, ~e, e});
        end
        alt_pin_level <= 5'h0A;
        apb_wr(32'h80, 32'h0);
        chk("alt", {timer_out_pin, sec, prim}, 5'h0A);
        for (int u = 0; u < 4; u++) apb_wr(32'(u) << 5, 32'h0);
    endtask : t_pins
    ////////////////////////////////////////
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; run = 4'h0;
        alt_pin_level = 5'h15; periodic_port_data = 2'b10;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_match;
        t_ext;
        t_div;
        t_pins;
        report_and_stop;
    end
endmodule : timer_frame_tb_top

// file: verilog/timer_frame.sv
// Four 10-bit timer units with APB registers, pins and interrupts
// Function
// - Four units, unit zero periodic, three compact, each with 10-bit counter.
// - Counters run freely; equality with comparator is a match that may clear.
// - Each unit has separate interrupt sources for comparator A and P.
// - Three-bit select picks system, high, timebase or external clock.
// - One external input per unit, used only when the select picks it.
// - Software chooses rising or falling active edge of the external input.
// - On match the output pin is set high, low, or toggled.
// - Unit waveform appears on its own output pin.
// - One control bit per pin chooses timer output or other function.
// - Periodic unit has two output pins, compact units one each.
// - Periodic pair can be complementary, polarity from port data bits.
// - Pin control bit 1 gives timer function, 0 keeps other function.
`include "timer_frame_regs.svh"

module timer_frame (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External count inputs, one per unit
    input  wire logic [3:0]  ext_count_input,
    // Polarity of the periodic pair, from port data bits
    input  wire logic [1:0]  periodic_port_data,
    // Alternative function levels for each output pin
    input  wire logic [4:0]  alt_pin_level,
    // Output pins: periodic_out_primary, periodic_out_secondary, compact 1..3
    output logic             periodic_out_primary,
    output logic             periodic_out_secondary,
    output logic [3:1]       timer_out_pin,
    // Interrupt
    output logic             irq
);
    import timer_frame_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [11:0] ctrl       [4];
    count_type   cmp_a      [4];
    count_type   cmp_p      [4];
    count_type   count      [4];
    logic [3:0]  out_level;
    logic [4:0]  pin_ctrl;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [2:0]  ext_sync   [4];
    logic [3:0]  ext_stable;
    logic [7:0]  div_count;

    logic [11:0] next_ctrl  [4];
    count_type   next_cmp_a [4];
    count_type   next_cmp_p [4];
    count_type   next_count [4];
    logic [3:0]  next_out_level;
    logic [4:0]  next_pin_ctrl;
    logic [7:0]  next_irq_status;
    logic [7:0]  next_irq_mask;
    logic [2:0]  next_ext_sync [4];
    logic [3:0]  next_ext_stable;
    logic [7:0]  next_div_count;
    logic [31:0] next_prdata;

    logic [3:0]  tick;
    logic [3:0]  ext_rise;
    logic [3:0]  ext_fall;
    logic [3:0]  match_a;
    logic [3:0]  match_p;
    logic        wr_en;
    logic        rd_en;
    logic        sys_en;
    logic        high16_en;
    logic        high64_en;
    logic        tb_en;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    // Zero wait states: every transfer ends in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler enables: one free divider gives every divided rate
    assign sys_en    = (div_count[1:0] == 2'h3);
    assign high16_en = (div_count[3:0] == 4'hF);
    assign high64_en = (div_count[5:0] == 6'h3F);
    assign tb_en     = (div_count == 8'hFF);

    always_comb begin
        next_div_count = div_count + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // External inputs: a level counts once the second and third flops
    // agree, so a single sampled glitch never makes an edge
    // Flops reset low, the idle level, so no false edge follows reset
    always_comb begin
        for (int i = 0; i < `NUM_UNITS; i++) begin
            logic agreed;
            agreed = (ext_sync[i][1] == ext_sync[i][2]);
            next_ext_sync[i]   = {ext_sync[i][1:0], ext_count_input[i]};
            next_ext_stable[i] = agreed ? ext_sync[i][2] : ext_stable[i];
            ext_rise[i] = agreed && ext_sync[i][2] && !ext_stable[i];
            ext_fall[i] = agreed && !ext_sync[i][2] && ext_stable[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter clock select and compare
    always_comb begin
        for (int i = 0; i < `NUM_UNITS; i++) begin
            logic [2:0] sel;
            sel = ctrl[i][`CTRL_CKSEL_LSB +: 3];
            case (sel)
                `CK_SYS_DIV4:   tick[i] = sys_en;
                `CK_SYS:        tick[i] = 1'b1;
                `CK_HIGH_DIV16: tick[i] = high16_en;
                `CK_HIGH_DIV64: tick[i] = high64_en;
                `CK_TIMEBASE:   tick[i] = tb_en;
                `CK_EXT_RISE:   tick[i] = ext_rise[i];
                `CK_EXT:        tick[i] = ctrl[i][`CTRL_EDGE_BIT]
                                          ? ext_fall[i]
                                          : ext_rise[i];
                default:        tick[i] = 1'b0;
            endcase
            match_a[i] = (count[i] == cmp_a[i]);
            match_p[i] = (count[i] == cmp_p[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters, outputs, registers
    always_comb begin
        next_pin_ctrl   = pin_ctrl;
        next_irq_mask   = irq_mask;
        next_irq_status = irq_status;
        next_out_level  = out_level;
        for (int i = 0; i < `NUM_UNITS; i++) begin
            logic [31:0]  base;
            out_mode_type mode;
            logic         hit;
            base = 32'(i) * `UNIT_STRIDE;
            mode = out_mode_type'(ctrl[i][`CTRL_OUTMODE_LSB +: 2]);
            next_ctrl[i]  = ctrl[i];
            next_cmp_a[i] = cmp_a[i];
            next_cmp_p[i] = cmp_p[i];
            next_count[i] = count[i];
            hit = 1'b0;
            if (ctrl[i][`CTRL_ON_BIT] && !ctrl[i][`CTRL_PAUSE_BIT]
                && tick[i]) begin
                next_count[i] = count[i] + 10'h001;
                // Both comparators act on one tick; a clear from either wins
                if (match_a[i]) begin
                    hit = 1'b1;
                    next_irq_status[2*i] = 1'b1;
                    if (ctrl[i][`CTRL_CLR_A_BIT]) begin
                        next_count[i] = '0;
                    end
                end
                if (match_p[i]) begin
                    hit = 1'b1;
                    next_irq_status[2*i+1] = 1'b1;
                    if (ctrl[i][`CTRL_CLR_P_BIT]) begin
                        next_count[i] = '0;
                    end
                end
                // One output action per tick, whichever comparator matched
                if (hit) begin
                    case (mode)
                        OUT_LOW:    next_out_level[i] = 1'b0;
                        OUT_HIGH:   next_out_level[i] = 1'b1;
                        OUT_TOGGLE: next_out_level[i] = !out_level[i];
                        default:    next_out_level[i] = out_level[i];
                    endcase
                end
            end
            // Turning a unit on restarts its count and loads its level
            if (wr_en && paddr == base + 32'(`OFS_CTRL)) begin
                next_ctrl[i] = pwdata[11:0];
                if (pwdata[`CTRL_ON_BIT] && !ctrl[i][`CTRL_ON_BIT]) begin
                    next_count[i] = '0;
                    next_out_level[i] = pwdata[`CTRL_INIT_BIT];
                end
            end
            if (wr_en && paddr == base + 32'(`OFS_CMP_A)) begin
                next_cmp_a[i] = pwdata[9:0];
            end
            if (wr_en && paddr == base + 32'(`OFS_CMP_P)) begin
                next_cmp_p[i] = pwdata[9:0];
            end
        end
        if (wr_en) begin
            case (paddr)
                `OFS_PIN_CTRL: next_pin_ctrl = pwdata[4:0];
                `OFS_IRQ_MASK: next_irq_mask = pwdata[7:0];
                `OFS_IRQ_STATUS: begin
                    // Write one to clear, a same-cycle event wins only on a flag that was clear
                    next_irq_status = next_irq_status
                                      | (irq_status & ~pwdata[7:0]);
                    for (int j = 0; j < 8; j++) begin
                        if (pwdata[j] && !(next_irq_status[j]
                            && !irq_status[j])) begin
                            next_irq_status[j] = 1'b0;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: loaded in the setup cycle, held until the next read,
    // so it stands through the access cycle
    always_comb begin
        next_prdata = prdata;
        if (rd_en) begin
            // Anything not decoded below reads as zero
            next_prdata = 32'h0000_0000;
            for (int i = 0; i < `NUM_UNITS; i++) begin
                logic [31:0] base;
                base = 32'(i) * `UNIT_STRIDE;
                if (paddr == base + 32'(`OFS_CTRL)) begin
                    next_prdata = {20'h0_0000, ctrl[i]};
                end
                if (paddr == base + 32'(`OFS_CMP_A)) begin
                    next_prdata = {22'h00_0000, cmp_a[i]};
                end
                if (paddr == base + 32'(`OFS_CMP_P)) begin
                    next_prdata = {22'h00_0000, cmp_p[i]};
                end
                if (paddr == base + 32'(`OFS_COUNT)) begin
                    next_prdata = {22'h00_0000, count[i]};
                end
            end
            case (paddr)
                `OFS_PIN_CTRL:   next_prdata = {27'h000_0000, pin_ctrl};
                `OFS_IRQ_STATUS: next_prdata = {24'h00_0000, irq_status};
                `OFS_IRQ_MASK:   next_prdata = {24'h00_0000, irq_mask};
                default:         ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers and prescaler
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < `NUM_UNITS; i++) begin
                ext_sync[i] <= 3'h0;
            end
            ext_stable <= 4'h0;
            div_count  <= 8'h00;
        end else begin
            ext_sync   <= next_ext_sync;
            ext_stable <= next_ext_stable;
            div_count  <= next_div_count;
        end
    end

    // Unit registers
    // Compare values reset to zero, so an enabled unit matches at once
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < `NUM_UNITS; i++) begin
                ctrl[i]  <= `CTRL_RESET;
                cmp_a[i] <= '0;
                cmp_p[i] <= '0;
                count[i] <= '0;
            end
            out_level <= 4'h0;
        end else begin
            ctrl      <= next_ctrl;
            cmp_a     <= next_cmp_a;
            cmp_p     <= next_cmp_p;
            count     <= next_count;
            out_level <= next_out_level;
        end
    end

    // Pin control and interrupt mask
    // Pins reset to their other function
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_ctrl <= `PIN_CTRL_RESET;
            irq_mask <= 8'h00;
        end else begin
            pin_ctrl <= next_pin_ctrl;
            irq_mask <= next_irq_mask;
        end
    end

    // Interrupt flags
    // Flags survive masking; only a written one clears them
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_status <= 8'h00;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sharing and interrupt output
    logic unit0_level;
    assign unit0_level = out_level[0] ^ ctrl[0][`CTRL_POL_BIT];

    // Periodic pair: port data bits set each pin's polarity
    always_comb begin
        periodic_out_primary   = pin_ctrl[0]
            ? unit0_level ^ periodic_port_data[0] : alt_pin_level[0];
        periodic_out_secondary = pin_ctrl[1]
            ? unit0_level ^ periodic_port_data[1] : alt_pin_level[1];
        // Compact units: one pin each, after the unit's own polarity
        for (int k = 1; k < `NUM_UNITS; k++) begin
            timer_out_pin[k] = pin_ctrl[k+1]
                ? out_level[k] ^ ctrl[k][`CTRL_POL_BIT]
                : alt_pin_level[k+1];
        end
    end

    // Level interrupt: high while any unmasked flag stands
    assign irq = |(irq_status & irq_mask);

endmodule : timer_frame

// file: verilog/timer_frame_pkg.sv
// Types shared by the timer frame
package timer_frame_pkg;
    typedef logic [9:0] count_type;
    typedef enum logic [1:0] {
        OUT_HOLD,
        OUT_LOW,
        OUT_HIGH,
        OUT_TOGGLE
    } out_mode_type;
endpackage : timer_frame_pkg

// file: verilog/timer_frame_regs.svh
// Register offsets, field positions, reset values for the timer frame
`ifndef TIMER_FRAME_REGS_SVH
`define TIMER_FRAME_REGS_SVH

// Per-unit register block: unit n at base n*0x20
`define UNIT_STRIDE      32'h0000_0020
`define OFS_CTRL         5'h00
`define OFS_CMP_A        5'h04
`define OFS_CMP_P        5'h08
`define OFS_COUNT        5'h0C
// Global registers
`define OFS_PIN_CTRL     32'h0000_0080
`define OFS_IRQ_STATUS   32'h0000_0084
`define OFS_IRQ_MASK     32'h0000_0088

// Control register fields
`define CTRL_ON_BIT      0
`define CTRL_PAUSE_BIT   1
`define CTRL_CKSEL_LSB   2
`define CTRL_EDGE_BIT    5
`define CTRL_OUTMODE_LSB 6
`define CTRL_CLR_P_BIT   8
`define CTRL_CLR_A_BIT   9
`define CTRL_INIT_BIT    10
`define CTRL_POL_BIT     11
`define CTRL_RESET       12'h000

// Clock select codes
`define CK_SYS_DIV4      3'h0
`define CK_SYS           3'h1
`define CK_HIGH_DIV16    3'h2
`define CK_HIGH_DIV64    3'h3
`define CK_TIMEBASE      3'h4
`define CK_EXT_RISE      3'h5
`define CK_EXT           3'h7

// Prescaler divisions of mclk
`define DIV_SYS          8'h04
`define DIV_HIGH16       8'h10
`define DIV_HIGH64       8'h40
`define DIV_TIMEBASE     8'hFF

`define PIN_CTRL_RESET   5'h00
`define COUNT_WIDTH      10
`define NUM_UNITS        4

`endif
